// File: core/touch_key_detect_sequencer.sv
`timescale 1ns/100ps
`default_nettype none
module drift_tick
  import touch_pkg::*;
#(
  parameter int unsigned PERIOD = 1000
) (
  input  wire logic clk_sys,
  input  wire logic reset,
  input  wire logic used,
  output logic      ready
);

  logic [CNT_W-1:0] cnt_q;
  logic             ready_q;

  assign ready = ready_q;

  // A tick that meets its own use is kept: setting wins over clearing
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cnt_q   <= '0;
      ready_q <= 1'b0;
    end else if (cnt_q >= CNT_W'(PERIOD - 1)) begin
      cnt_q   <= '0;
      ready_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + CNT_W'(1);
      if (used) begin
        ready_q <= 1'b0;
      end
    end
  end

endmodule

module touch_key_detect_sequencer
  import touch_pkg::*;
#(
  parameter int unsigned FAST_GAP_CYCLES  = FAST_GAP_CYC,
  parameter int unsigned LP_GAP_CYCLES    = LP_GAP_CYC,
  parameter int unsigned POS_DRIFT_CYCLES = POS_DRIFT_CYC,
  parameter int unsigned NEG_DRIFT_CYCLES = NEG_DRIFT_CYC,
  parameter int unsigned MAX_ON_COUNT     = MAX_ON_BURSTS
) (
  input  wire logic                clk_sys,
  input  wire logic                reset,
  input  wire logic                sync_in,
  input  wire sample_t             sample_in,
  output logic                     burst_req,
  output logic [SPREAD_W-1:0]      spread_code,
  output pin_t                     out_pin,
  output run_mode_t                run_mode
);

  seq_state_t                  state_q;
  run_mode_t                   mode_q;
  logic [CNT_W-1:0]            timer_q;
  logic                        burst_q;
  logic                        oe_q;
  logic                        sync_ref_q;
  logic [CNT_W-1:0]            chg_cnt_q;
  logic signed [SPREAD_W-1:0]  spread_q;
  logic                        spread_up_q;
  logic [SAMPLE_W-1:0]         ref_q;
  logic                        recal_q;
  logic                        det_q;
  logic [2:0]                  integ_q;
  logic [ON_W-1:0]             on_cnt_q;
  logic                        pos_pend_q;
  logic                        neg_pend_q;

  logic                        take;
  logic signed [DELTA_W-1:0]   delta;
  logic                        over;
  logic                        below_hyst;
  logic                        pending;
  logic [CNT_W-1:0]            gap_len;
  logic                        sync_change;
  logic                        sync_idle;
  logic                        gap_done;
  logic                        drift_up;
  logic                        drift_dn;
  logic [2:0]                  integ_need;
  logic [2:0]                  integ_inc;
  logic [1:0]                  drift_ready;
  logic [1:0]                  drift_used;

  assign burst_req     = burst_q;
  assign spread_code   = spread_q;
  assign out_pin.level = det_q;
  assign out_pin.oe    = oe_q;
  assign run_mode      = mode_q;

  // A sample is only accepted while a burst is open
  assign take = (state_q == ST_BURST) && sample_in.valid;

  // Comparison levels sit on the reference, so drift moves both together
  assign delta = $signed({1'b0, sample_in.count}) - $signed({1'b0, ref_q});
  assign over       = (delta >= THRESH);
  assign below_hyst = (delta < (THRESH - HYST));

  // An integrator that has started but not finished means an open touch
  assign pending = (integ_q != 3'h0);

  always_comb begin
    if (mode_q == MODE_LOW_POWER && !pending) begin
      gap_len = CNT_W'(LP_GAP_CYCLES);
    end else begin
      gap_len = CNT_W'(FAST_GAP_CYCLES);
    end
  end

  // A level must hold its new value for the least pulse width
  assign sync_change = (sync_in != sync_ref_q) &&
                       (chg_cnt_q >= CNT_W'(SYNC_MIN_CYC - 1));
  assign sync_idle   = (timer_q >= CNT_W'(LP_GAP_CYCLES - 1));
  assign gap_done    = (timer_q >= gap_len - CNT_W'(1));

  assign integ_need = (mode_q == MODE_SYNC) ? INTEG_SYNC : INTEG_FULL;
  assign integ_inc  = integ_q + 3'h1;

  // Drift applies only to an idle, non-detecting, calibrated channel
  assign drift_up = take && !recal_q && !det_q && !over && !pending &&
                    (sample_in.count > ref_q) && pos_pend_q;
  assign drift_dn = take && !recal_q && !det_q && !pending &&
                    (sample_in.count < ref_q) && neg_pend_q;

  // Burst sequencing, health pulse and trigger sampling
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_q    <= ST_GAP;
      timer_q    <= '0;
      burst_q    <= 1'b0;
      oe_q       <= 1'b1;
      sync_ref_q <= 1'b1;
    end else begin
      case (state_q)
        ST_GAP: begin
          timer_q <= timer_q + CNT_W'(1);
          if (mode_q == MODE_SYNC) begin
            if (sync_change) begin
              timer_q <= '0;
              state_q <= ST_BEAT;
              oe_q    <= 1'b0;
            end else if (sync_idle) begin
              timer_q <= '0;
              if (sync_in) begin
                state_q <= ST_BURST;
                burst_q <= 1'b1;
              end else begin
                state_q <= ST_BEAT;
                oe_q    <= 1'b0;
              end
            end
          end else if (gap_done) begin
            timer_q <= '0;
            if (mode_q == MODE_FAST) begin
              state_q <= ST_BURST;
              burst_q <= 1'b1;
            end else begin
              state_q <= ST_BEAT;
              oe_q    <= 1'b0;
            end
          end
        end
        ST_BEAT: begin
          timer_q <= timer_q + CNT_W'(1);
          if (timer_q >= CNT_W'(BEAT_CYC - 1)) begin
            timer_q <= '0;
            oe_q    <= 1'b1;
            state_q <= ST_BURST;
            burst_q <= 1'b1;
          end
        end
        ST_BURST: begin
          if (sample_in.valid) begin
            burst_q    <= 1'b0;
            state_q    <= ST_GAP;
            timer_q    <= '0;
            // Trigger is looked at once, as the burst closes; a pulse
            // that ends inside the burst is therefore not a new change
            sync_ref_q <= sync_in;
          end
        end
        default: begin
          state_q <= ST_GAP;
          timer_q <= '0;
          burst_q <= 1'b0;
          oe_q    <= 1'b1;
        end
      endcase
    end
  end

  // Run mode moves only as a burst closes or a sync sleep runs out;
  // a trigger change in mid-burst never switches the pace directly
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      mode_q <= MODE_FAST;
    end else if (state_q == ST_BURST && sample_in.valid) begin
      if (mode_q == MODE_FAST && !sync_in) begin
        mode_q <= MODE_SYNC;
      end else if (mode_q == MODE_LOW_POWER && sync_in) begin
        mode_q <= MODE_FAST;
      end
    end else if (state_q == ST_GAP && mode_q == MODE_SYNC &&
                 !sync_change && sync_idle) begin
      if (sync_in) begin
        mode_q <= MODE_FAST;
      end else begin
        mode_q <= MODE_LOW_POWER;
      end
    end
  end

  // Trigger level qualifier
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      chg_cnt_q <= '0;
    end else if (state_q == ST_GAP && mode_q == MODE_SYNC &&
                 sync_in != sync_ref_q) begin
      if (!sync_change) begin
        chg_cnt_q <= chg_cnt_q + CNT_W'(1);
      end
    end else begin
      chg_cnt_q <= '0;
    end
  end

  // Triangle sweep of the oscillator trim while a burst runs
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      spread_q    <= '0;
      spread_up_q <= 1'b1;
    end else if (!burst_q) begin
      spread_q    <= '0;
      spread_up_q <= 1'b1;
    end else if (spread_up_q) begin
      if (spread_q >= SPREAD_LIM) begin
        spread_up_q <= 1'b0;
        spread_q    <= spread_q - SPREAD_W'(1);
      end else begin
        spread_q <= spread_q + SPREAD_W'(1);
      end
    end else begin
      if (spread_q <= -SPREAD_LIM) begin
        spread_up_q <= 1'b1;
        spread_q    <= spread_q + SPREAD_W'(1);
      end else begin
        spread_q <= spread_q - SPREAD_W'(1);
      end
    end
  end

  // Detection, integrator, max on-duration and recalibration
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      recal_q  <= 1'b1;
      det_q    <= 1'b0;
      integ_q  <= 3'h0;
      on_cnt_q <= '0;
      ref_q    <= '0;
    end else if (take) begin
      if (recal_q) begin
        ref_q    <= sample_in.count;
        recal_q  <= 1'b0;
        det_q    <= 1'b0;
        integ_q  <= 3'h0;
        on_cnt_q <= '0;
      end else if (det_q) begin
        if (below_hyst) begin
          det_q    <= 1'b0;
          on_cnt_q <= '0;
        end else if (on_cnt_q >= ON_W'(MAX_ON_COUNT - 1)) begin
          // Timeout: drop the output now, rebuild reference next sample
          det_q    <= 1'b0;
          recal_q  <= 1'b1;
          on_cnt_q <= '0;
        end else begin
          on_cnt_q <= on_cnt_q + ON_W'(1);
        end
      end else if (over) begin
        if (integ_inc >= integ_need) begin
          det_q   <= 1'b1;
          integ_q <= 3'h0;
        end else begin
          integ_q <= integ_inc;
        end
      end else begin
        integ_q <= 3'h0;
        if (drift_up) begin
          ref_q <= ref_q + SAMPLE_W'(1);
        end else if (drift_dn) begin
          ref_q <= ref_q - SAMPLE_W'(1);
        end
      end
    end
  end

  // Drift rate limiters: index 0 paces rising, index 1 falling drift
  assign drift_used = {drift_dn, drift_up};
  assign pos_pend_q = drift_ready[0];
  assign neg_pend_q = drift_ready[1];

  // Falling drift gets the shorter period, so a lifted cover recovers fast
  for (genvar g = 0; g < 2; g++) begin : g_drift
    drift_tick #(
      .PERIOD((g == 0) ? POS_DRIFT_CYCLES : NEG_DRIFT_CYCLES)
    ) drift_tick_inst (
      .clk_sys(clk_sys),
      .reset  (reset),
      .used   (drift_used[g]),
      .ready  (drift_ready[g])
    );
  end

endmodule
`default_nettype wire

// File: inc/touch_pkg.sv
package touch_pkg;

  // Clock and time base
  localparam int unsigned CLK_HZ       = 125_000_000;
  localparam int unsigned CYC_PER_US   = CLK_HZ / 1_000_000;
  localparam int unsigned CYC_PER_MS   = CLK_HZ / 1_000;

  // Burst pacing
  localparam int unsigned FAST_GAP_MS  = 1;
  localparam int unsigned LP_GAP_MS    = 70;
  localparam int unsigned FAST_GAP_CYC = FAST_GAP_MS * CYC_PER_MS;
  localparam int unsigned LP_GAP_CYC   = LP_GAP_MS * CYC_PER_MS;

  // Health pulse on the output pin
  localparam int unsigned BEAT_US      = 15;
  localparam int unsigned BEAT_CYC     = BEAT_US * CYC_PER_US;

  // Least width of a trigger level before it counts as a change
  localparam int unsigned SYNC_MIN_US  = 10;
  localparam int unsigned SYNC_MIN_CYC = SYNC_MIN_US * CYC_PER_US;

  // Drift compensation, one level per period
  localparam int unsigned POS_DRIFT_MS  = 2000;
  localparam int unsigned NEG_DRIFT_MS  = 1000;
  localparam int unsigned POS_DRIFT_CYC = POS_DRIFT_MS * CYC_PER_MS;
  localparam int unsigned NEG_DRIFT_CYC = NEG_DRIFT_MS * CYC_PER_MS;

  // Max on-duration, counted in measurements at the fast pace
  localparam int unsigned MAX_ON_S      = 60;
  localparam int unsigned MAX_ON_BURSTS = MAX_ON_S * 1000 / FAST_GAP_MS;

  // Signal processing
  localparam int unsigned SAMPLE_W     = 12;
  localparam int unsigned DELTA_W      = SAMPLE_W + 1;
  localparam logic signed [DELTA_W-1:0] THRESH = 13'sh00A;
  localparam logic signed [DELTA_W-1:0] HYST   = 13'sh002;
  localparam logic [2:0] INTEG_FULL    = 3'h4;
  localparam logic [2:0] INTEG_SYNC    = 3'h1;

  // Oscillator spread, in steps of 0.1 percent
  localparam int unsigned SPREAD_W     = 8;
  localparam logic signed [SPREAD_W-1:0] SPREAD_LIM = 8'sh4B;

  // Counter widths: CNT_W for all cycle timers, ON_W for the on-duration count
  localparam int unsigned CNT_W        = 32;
  localparam int unsigned ON_W         = 20;

  typedef enum logic [1:0] {
    MODE_FAST,
    MODE_LOW_POWER,
    MODE_SYNC
  } run_mode_t;

  typedef enum logic [1:0] {
    ST_GAP,
    ST_BEAT,
    ST_BURST
  } seq_state_t;

  typedef struct packed {
    logic                valid;
    logic [SAMPLE_W-1:0] count;
  } sample_t;

  typedef struct packed {
    logic level;
    logic oe;
  } pin_t;

endpackage

// File: verification/touch_front_model.sv
`timescale 1ns/100ps
`default_nettype none
module touch_front_model
  import touch_pkg::*;
(
  input  wire logic                clk_sys,
  input  wire logic                burst_req,
  input  wire logic [SAMPLE_W-1:0] count_val,
  input  wire logic [7:0]          lag,
  output sample_t                  sample_out
);
  logic [7:0] wait_q;
  logic       done_q;
  initial begin
    sample_out = '0;
    wait_q = 8'h00;
    done_q = 1'b0;
  end
  // Count lines toggle between results so stale data never looks fresh
  always @(negedge clk_sys) begin
    sample_out.valid <= 1'b0;
    sample_out.count <= ~sample_out.count;
    if (!burst_req) begin
      wait_q <= 8'h00;
      done_q <= 1'b0;
    end else if (!done_q && wait_q == lag) begin
      sample_out <= {1'b1, count_val};
      done_q <= 1'b1;
    end else begin
      wait_q <= wait_q + 8'h01;
    end
  end
endmodule
`default_nettype wire

// File: verification/touch_key_detect_sequencer_bench.sv
`timescale 1ns/100ps
`default_nettype none
module touch_key_detect_sequencer_bench;
  import touch_pkg::*;
  localparam int FG = 50;
  localparam int LPG = 4000;
  localparam int WAKE = SYNC_MIN_CYC + BEAT_CYC;
  logic                clk_sys = 1'b0;
  logic                reset = 1'b1;
  logic                sync_in = 1'b1;
  logic [SAMPLE_W-1:0] count_val = 12'h064;
  logic [7:0]          lag = 8'h03;
  sample_t             sample_in;
  logic                burst_req;
  logic [SPREAD_W-1:0] spread_code;
  pin_t                out_pin;
  run_mode_t           run_mode;
  int                  err_count = 0;
  int                  n_compared = 0;
  touch_key_detect_sequencer #(.FAST_GAP_CYCLES(FG), .LP_GAP_CYCLES(LPG),
    .POS_DRIFT_CYCLES(20000), .NEG_DRIFT_CYCLES(10000), .MAX_ON_COUNT(8)
  ) touch_key_detect_sequencer_inst (.clk_sys(clk_sys), .reset(reset),
    .sync_in(sync_in), .sample_in(sample_in), .burst_req(burst_req),
    .spread_code(spread_code), .out_pin(out_pin), .run_mode(run_mode));
  touch_front_model touch_front_model_inst (.clk_sys(clk_sys),
    .burst_req(burst_req), .count_val(count_val), .lag(lag),
    .sample_out(sample_in));
  initial begin
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    if (err_count == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic do_reset();
    reset = 1'b1;
    repeat (10) @(negedge clk_sys);
    reset = 1'b0;
  endtask
  // Answer the next burst with count c, return the level that follows
  task automatic take(input logic [11:0] c, output logic l);
    int i;
    count_val = c;
    i = 0;
    do begin
      @(posedge clk_sys);
      i++;
    end while (!(burst_req && sample_in.valid) && i < 40000);
    if (i >= 40000) err_count++;
    @(negedge clk_sys);
    l = out_pin.level;
  endtask
  task automatic gap(output int n);
    n = 0;
    while (!burst_req && n < 40000) begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= 40000) err_count++;
  endtask
  task automatic t_fast();
    logic l;
    int   n;
    take(12'h064, l);
    gap(n);
    check(16'(n >= FG - 1 && n <= FG + 3), 16'h0001);
    check(16'(out_pin.oe), 16'h0001);
  endtask
  task automatic t_detect();
    logic [11:0] c [10] = '{12'h06D, 12'h06D, 12'h06E, 12'h06E, 12'h06E,
                            12'h064, 12'h06E, 12'h06E, 12'h06E, 12'h06E};
    logic l;
    lag = 8'h28;
    for (int i = 0; i < 10; i++) begin
      take(c[i], l);
      check(16'(l), 16'(i == 9));
    end
    lag = 8'h03;
  endtask
  task automatic t_release();
    logic [11:0] c [3] = '{12'h06C, 12'h06C, 12'h06B};
    logic l;
    for (int i = 0; i < 3; i++) begin
      take(c[i], l);
      check(16'(l), 16'(i < 2));
    end
  endtask
  task automatic t_maxon();
    logic l;
    int   hi;
    hi = 0;
    for (int i = 0; i < 16; i++) begin
      take(12'h06E, l);
      hi += int'(l);
    end
    check(16'(hi >= 7 && hi <= 9), 16'h0001);
    check(16'(l), 16'h0000);
    for (int i = 0; i < 4; i++) begin
      take(12'h078, l);
      check(16'(l), 16'(i == 3));
    end
  endtask
  task automatic t_sync();
    logic l;
    int   n;
    take(12'h06E, l);
    sync_in = 1'b0; // Low across a whole burst
    take(12'h06E, l);
    check(16'(run_mode), 16'(MODE_SYNC));
    repeat (100) @(negedge clk_sys);
    check(16'(burst_req), 16'h0000);
    sync_in = 1'b1;
    gap(n);
    check(16'(n >= WAKE - 1 && n <= WAKE + 4), 16'h0001);
    take(12'h078, l);
    check(16'(l), 16'h0001);
    sync_in = 1'b0;
    gap(n);
    check(16'(n >= WAKE - 1 && n <= WAKE + 4), 16'h0001);
    take(12'h06E, l);
    sync_in = 1'b1; // Pulse wider than the minimum
    repeat (2000) @(negedge clk_sys);
    sync_in = 1'b0;
    n = 0;
    repeat (2 * WAKE) begin
      @(posedge clk_sys);
      n += int'(burst_req && sample_in.valid);
    end
    check(16'(n), 16'h0001);
    repeat (1500) @(negedge clk_sys);
    check(16'(run_mode), 16'(MODE_LOW_POWER));
  endtask
  task automatic t_lp();
    logic l;
    int   n;
    take(12'h06E, l);
    gap(n);
    check(16'(n >= LPG + BEAT_CYC - 1 && n <= LPG + BEAT_CYC + 4), 16'h0001);
    take(12'h078, l);
    gap(n);
    check(16'(n < LPG), 16'h0001);
    for (int i = 0; i < 3; i++) take(12'h078, l);
    check(16'(l), 16'h0001);
    take(12'h06E, l);
    gap(n);
    check(16'(n >= LPG), 16'h0001);
    sync_in = 1'b1;
    take(12'h06E, l);
    check(16'(run_mode), 16'(MODE_FAST));
  endtask
  // One rising step of drift fits the wait; a second would need 40000
  task automatic t_drift();
    logic l;
    do_reset();
    take(12'h064, l);
    count_val = 12'h069;
    repeat (30000) @(negedge clk_sys);
    for (int i = 0; i < 8; i++) begin
      take(i < 4 ? 12'h06E : 12'h06F, l);
      check(16'(l), 16'(i == 7));
    end
  endtask
  initial begin
    do_reset();
    t_fast();
    t_detect();
    t_release();
    t_maxon();
    t_sync();
    t_lp();
    t_drift();
    end_of_test();
  end
  initial begin
    repeat (100000) @(posedge clk_sys);
    err_count++;
    end_of_test();
  end
endmodule
bind touch_key_detect_sequencer touch_seq_chk #(
  .FAST_GAP_CYCLES(FAST_GAP_CYCLES)
) touch_seq_chk_inst (.clk_sys(clk_sys), .reset(reset), .sync_in(sync_in),
  .sample_in(sample_in), .burst_req(burst_req), .spread_code(spread_code),
  .out_pin(out_pin), .run_mode(run_mode));
`default_nettype wire

// File: verification/touch_seq_chk.sv
`timescale 1ns/100ps
`default_nettype none
module touch_seq_chk
  import touch_pkg::*;
#(
  parameter int FAST_GAP_CYCLES = 50
) (
  input wire logic                clk_sys,
  input wire logic                reset,
  input wire logic                sync_in,
  input wire sample_t             sample_in,
  input wire logic                burst_req,
  input wire logic [SPREAD_W-1:0] spread_code,
  input wire pin_t                out_pin,
  input wire run_mode_t           run_mode
);
  localparam int GAP_LO = FAST_GAP_CYCLES - 1;
  localparam int GAP_HI = FAST_GAP_CYCLES + 3;
  logic        take;
  logic [11:0] beat_q;
  assign take = burst_req && sample_in.valid;
  // Counts floating cycles so the beat width is judged exactly
  always_ff @(posedge clk_sys) begin
    if (reset || out_pin.oe) begin
      beat_q <= 12'h000;
    end else begin
      beat_q <= beat_q + 12'h001;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  property p_burst_end; take |=> !burst_req; endproperty
  a_burst_end: assert property (p_burst_end)
    else $error("burst held after its sample");
  property p_spread;
    $signed(spread_code) <= SPREAD_LIM && $signed(spread_code) >= -SPREAD_LIM
      && (spread_code == 8'h00 || burst_req || $past(burst_req));
  endproperty
  a_spread: assert property (p_spread)
    else $error("spread code out of band");
  property p_spread_move; $rose(burst_req) |=> spread_code == 8'h01; endproperty
  a_spread_move: assert property (p_spread_move)
    else $error("spread sweep did not start");
  property p_fast_gap;
    $fell(burst_req) && run_mode == MODE_FAST |-> ##[GAP_LO:GAP_HI] $rose(burst_req);
  endproperty
  a_fast_gap: assert property (p_fast_gap)
    else $error("fast gap wrong");
  property p_beat; $rose(out_pin.oe) |-> beat_q == 12'(BEAT_CYC) && burst_req; endproperty
  a_beat: assert property (p_beat)
    else $error("health pulse width wrong");
  property p_no_beat_fast; run_mode == MODE_FAST |-> out_pin.oe; endproperty
  a_no_beat_fast: assert property (p_no_beat_fast)
    else $error("pin floated in fast mode");
  property p_level_at_sample; $changed(out_pin.level) |-> $past(take); endproperty
  a_level_at_sample: assert property (p_level_at_sample)
    else $error("detect level moved between samples");
  property p_mode_at_sample;
    $changed(run_mode) && $past(run_mode) != MODE_SYNC |-> $past(take);
  endproperty
  a_mode_at_sample: assert property (p_mode_at_sample)
    else $error("mode changed off a burst end");
  property p_fast_to_sync;
    take && run_mode == MODE_FAST && !sync_in |=> run_mode == MODE_SYNC;
  endproperty
  a_fast_to_sync: assert property (p_fast_to_sync)
    else $error("sync mode not entered");
  property p_lp_to_fast;
    take && run_mode == MODE_LOW_POWER && sync_in |=> run_mode == MODE_FAST;
  endproperty
  a_lp_to_fast: assert property (p_lp_to_fast)
    else $error("fast mode not entered");
endmodule
`default_nettype wire
